//--- verilog/dgc_pkg.sv
// package: register map, field layout and bus carriers of the global config slice
package dgc_pkg;

  localparam logic [11:0] addr_status = 12'h000;
  localparam logic [11:0] addr_global_config = 12'h004;
  localparam logic [11:0] addr_control_table_base = 12'h008;
  localparam int addr_width = 12;

  localparam int enable_bit = 0;
  localparam int table_base_lsb = 10;
  localparam int table_base_msb = 31;

  localparam logic [31:0] global_config_reset = 32'h0000_0000;
  localparam logic [31:0] control_table_base_reset = 32'h0000_0000;

  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } dgc_read_type;

endpackage

//--- verilog/dgc_reg_field.sv
// one software-writable register field with byte-lane strobes and synchronous reset
`timescale 1ns/100ps
`default_nettype none
module dgc_reg_field #(
  parameter int lsb = 0,
  parameter int msb = 31,
  parameter logic [31:0] reset_value = 32'h0000_0000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic write_en,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic [31:0] value
);

  // the per-bit loop below can only serve a field inside one 32-bit word
  if (lsb < 0 || msb > 31 || lsb > msb) begin : g_bad_range
    $error("dgc_reg_field: bad field range");
  end

  logic [31:0] field_reg;
  logic [31:0] field_next;
  logic [31:0] lane_mask;
  logic [31:0] field_mask;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_bit
      assign lane_mask[gi] = wstrb[gi / 8];
      assign field_mask[gi] = (gi >= lsb) && (gi <= msb);
    end
  endgenerate

  // reserved bits never store, so they read back zero
  assign field_next = write_en
    ? ((field_reg & ~lane_mask) | (wdata & lane_mask)) & field_mask
    : field_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_reg <= reset_value & field_mask;
    end else begin
      field_reg <= field_next;
    end
  end

  assign value = field_reg;

endmodule
`default_nettype wire

//--- verilog/dgc_global_config.sv
// top: global enable and control-table base registers behind an axi4-lite slave
// What this block does
// RULE1: bit 0 enables or disables whole controller
// RULE2: configuration register resets to zero, disabled
// RULE3: bits 31:10 hold control table pointer
// RULE4: software aligns table to 1024-byte boundary
// RULE5: control-base register resets to zero
// RULE6: status bit 0 mirrors global enable
// RULE7: reserved bits ignore writes, read zero
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module dgc_global_config (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic controller_global_enable,
  output logic [31:0] control_table_base
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks: the decode keeps only word bits 11:2 of a 12-bit address
  if (dgc_pkg::addr_width != 12) begin : g_bad_addr_width
    $error("dgc_global_config: address ports are 12 bits wide");
  end
  if (dgc_pkg::addr_status[1:0] != 2'h0 || dgc_pkg::addr_global_config[1:0] != 2'h0 ||
      dgc_pkg::addr_control_table_base[1:0] != 2'h0) begin : g_bad_alignment
    $error("dgc_global_config: register offsets must be word aligned");
  end
  if (dgc_pkg::addr_status == dgc_pkg::addr_global_config ||
      dgc_pkg::addr_status == dgc_pkg::addr_control_table_base ||
      dgc_pkg::addr_global_config == dgc_pkg::addr_control_table_base) begin : g_bad_overlap
    $error("dgc_global_config: register offsets overlap");
  end
  // a pointer field reaching bit 0 would leave no room for the table alignment
  if (dgc_pkg::table_base_lsb < 1 || dgc_pkg::table_base_msb > 31 ||
      dgc_pkg::table_base_lsb > dgc_pkg::table_base_msb) begin : g_bad_pointer
    $error("dgc_global_config: table pointer field outside the word");
  end
  if (dgc_pkg::enable_bit < 0 || dgc_pkg::enable_bit > 31) begin : g_bad_enable
    $error("dgc_global_config: enable bit outside the word");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write channel: address and data caught in either order
  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  logic awready_reg;
  logic wready_reg;

  // a beat is taken only where ready was shown; a master that keeps valid up
  // across a busy spell would otherwise be caught twice
  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take = s_axi_wvalid && wready_reg;
  wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_done = bvalid_reg && s_axi_bready;
  // low address bits pick a byte, which a word-wide register ignores
  wire [9:0] wr_word = awaddr_reg[11:2];
  wire wr_cfg_hit = wr_word == dgc_pkg::addr_global_config[11:2];
  wire wr_base_hit = wr_word == dgc_pkg::addr_control_table_base[11:2];
  // status is read only, so a write there is refused like an unmapped one
  wire wr_hit = wr_cfg_hit || wr_base_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= dgc_pkg::resp_okay;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      // wr_go needs bvalid low, so a new response never meets an old one
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? dgc_pkg::resp_okay : dgc_pkg::resp_slverr;
      end else if (wr_done) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ready is a registered level: low from a take until a cycle after the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else begin
      awready_reg <= !(aw_held_reg || aw_take) && !(wr_go || bvalid_reg);
      wready_reg <= !(w_held_reg || w_take) && !(wr_go || bvalid_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register storage
  // both registers see the captured word and strobes; only the hit one stores
  logic [31:0] config_value;
  logic [31:0] base_value;

  dgc_reg_field #(
    .lsb(dgc_pkg::enable_bit),
    .msb(dgc_pkg::enable_bit),
    .reset_value(dgc_pkg::global_config_reset)
  ) u_config ( // RULE1 RULE2 RULE7
    .aclk(aclk),
    .aresetn(aresetn),
    .write_en(wr_go && wr_cfg_hit),
    .wdata(wdata_reg),
    .wstrb(wstrb_reg),
    .value(config_value)
  );

  dgc_reg_field #(
    .lsb(dgc_pkg::table_base_lsb),
    .msb(dgc_pkg::table_base_msb),
    .reset_value(dgc_pkg::control_table_base_reset)
  ) u_base ( // RULE3 RULE5 RULE7
    .aclk(aclk),
    .aresetn(aresetn),
    .write_en(wr_go && wr_base_hit),
    .wdata(wdata_reg),
    .wstrb(wstrb_reg),
    .value(base_value)
  );

  // low ten bits are stored as zero, so any pointer given is 1024-byte aligned
  assign control_table_base = base_value; // RULE4
  assign controller_global_enable = config_value[dgc_pkg::enable_bit]; // RULE1

  ////////////////////////////////////////////////////////////////////////////////
  // read channel
  logic rvalid_reg;
  logic arready_reg;
  dgc_pkg::dgc_read_type rd_reg;
  dgc_pkg::dgc_read_type rd_next;

  wire ar_take = s_axi_arvalid && arready_reg;
  wire rd_done = rvalid_reg && s_axi_rready;
  wire [9:0] rd_word = s_axi_araddr[11:2];
  wire rd_stat_hit = rd_word == dgc_pkg::addr_status[11:2];
  wire rd_cfg_hit = rd_word == dgc_pkg::addr_global_config[11:2];
  wire rd_base_hit = rd_word == dgc_pkg::addr_control_table_base[11:2];
  // status shows only the enable mirror; its other fields belong elsewhere
  wire [31:0] status_value = {31'h0000_0000, config_value[dgc_pkg::enable_bit]}; // RULE6

  always_comb begin
    rd_next.resp = dgc_pkg::resp_okay;
    rd_next.data = 32'h0000_0000;
    if (rd_stat_hit) begin
      rd_next.data = status_value; // RULE6
    end else if (rd_cfg_hit) begin
      rd_next.data = config_value; // RULE7
    end else if (rd_base_hit) begin
      rd_next.data = base_value; // RULE7
    end else begin
      rd_next.resp = dgc_pkg::resp_slverr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rd_reg <= '0;
    end else begin
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        arready_reg <= 1'b0;
        rd_reg <= rd_next;
      end else if (rd_done) begin
        rvalid_reg <= 1'b0;
      // ready returns only after the answer is gone, so one read is open at most
      end else if (!rvalid_reg) begin
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rd_reg.data;
  assign s_axi_rresp = rd_reg.resp;

endmodule
`default_nettype wire

//--- testbench/dgc_chk.sv
// checker: bus and output relations of the global config slice
`timescale 1ns/100ps
`default_nettype none
module dgc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic controller_global_enable,
  input wire logic [31:0] control_table_base
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic tk = s_axi_arvalid && s_axi_arready;
  ////////////////////////////////
  // reset is the cause here, so it must not disable the check
  a_reset_clear: assert property (disable iff (1'h0) !aresetn |=>
    !controller_global_enable && control_table_base == 32'h0) else $error("reset not clear");
  a_base_reserved: assert property (control_table_base[9:0] == 10'h0)
    else $error("base low bits set");
  a_enable_change: assert property ($changed(controller_global_enable) |->
    $rose(s_axi_bvalid)) else $error("enable moved without write");
  a_base_change: assert property ($changed(control_table_base) |->
    $rose(s_axi_bvalid)) else $error("base moved without write");
  a_read_answer: assert property (tk |=> s_axi_rvalid) else $error("no read answer");
  a_status_mirror: assert property (tk && s_axi_araddr == dgc_pkg::addr_status |=>
    s_axi_rdata == {31'h0, $past(controller_global_enable)}) else $error("status bad");
  a_config_read: assert property (tk && s_axi_araddr == dgc_pkg::addr_global_config |=>
    s_axi_rdata == {31'h0, $past(controller_global_enable)}) else $error("config bad");
  a_base_read: assert property (tk && s_axi_araddr == dgc_pkg::addr_control_table_base |=>
    s_axi_rdata == $past(control_table_base)) else $error("base read bad");
endmodule
bind dgc_global_config dgc_chk u_chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid, .controller_global_enable,
  .control_table_base);
`default_nettype wire

//--- testbench/tb_dgc_global_config.sv
// testbench: register behaviour of the global config slice
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_dgc_global_config;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic controller_global_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
  logic [31:0] s_axi_rdata, control_table_base, rd;
  int num_errors = 0, num_checks = 0;
  // row: waddr wdata wstrb raddr rdata {bresp,rresp}
  localparam logic [95:0] rows [8] = '{
    96'h004_ffffffff_f_004_00000001_0, 96'h008_ffffffff_f_008_fffffc00_0,
    96'h004_00000000_f_004_00000000_0, 96'h008_12345678_3_008_ffff5400_0,
    96'h000_00000001_f_000_00000000_8, 96'h00c_ffffffff_f_00c_00000000_a,
    96'h004_00000001_f_000_00000001_0, 96'h008_20000400_f_008_20000400_0};
  dgc_global_config u_dut (.*);
  initial begin
    forever #50 aclk = ~aclk;
  end
  ////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // each channel let go only at its own accepting edge
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    br = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////
  // whole run is about 100 cycles, so 2000 cycles means a hang
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rd_reg(12'h004);
    `CHK("config reset", 32'h0, rd)
    rd_reg(12'h008);
    `CHK("base reset", 32'h0, rd)
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][95:84], rows[i][83:52], rows[i][51:48]);
      `CHK("bresp", rows[i][3:2], br)
      rd_reg(rows[i][47:36]);
      `CHK("rdata", rows[i][35:4], rd)
      `CHK("rresp", rows[i][1:0], rr)
    end
    `CHK("enable out", 1'h1, controller_global_enable)
    `CHK("base out", 32'h20000400, control_table_base)
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    `CHK("enable after reset", 1'h0, controller_global_enable)
    `CHK("base after reset", 32'h0, control_table_base)
    aresetn <= 1'h1;
    rd_reg(12'h004);
    `CHK("config read after reset", 32'h0, rd)
    rd_reg(12'h000);
    `CHK("status read after reset", 32'h0, rd)
    rd_reg(12'h008);
    `CHK("base read after reset", 32'h0, rd)
    report_and_stop();
  end
endmodule
`default_nettype wire
